// [inc/csp_pkg.sv]
package csp_pkg;
  // Bit time is a plain default; raise it for slow peers
  localparam int CLK_MHZ = 200;
  localparam int BIT_TIME_NS = 160;
  localparam int BIT_CYCLES = (BIT_TIME_NS * CLK_MHZ) / 1000;
  localparam int BIT_CNT_W = 11;
  // Frame layout: start, 8 data, stop
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  // Peer-drop alarm number
  localparam logic [7:0] ALARM_PEER_DROP = 8'h56;
  // Device-control codes, channel bits 8..1 map to [7:0]
  localparam logic [7:0] CODE_DC1 = 8'h11;
  localparam logic [7:0] CODE_DC2 = 8'h12;
  localparam logic [7:0] CODE_DC3 = 8'h93;
  localparam logic [7:0] CODE_DC4 = 8'h14;
  // Character set select
  localparam logic SET_EIA = 1'b0;
  localparam logic SET_ISO = 1'b1;
  // Characters allowed after stop-reader or permit drop
  localparam logic [3:0] STOP_READER_MAX = 4'hA;
  localparam logic [1:0] PERMIT_MAX = 2'h2;
  typedef enum logic [1:0] {
    CSP_IDLE = 2'b00,
    CSP_START = 2'b01,
    CSP_DATA = 2'b10,
    CSP_STOP = 2'b11
  } csp_state_t;
endpackage

// [hdl/csp_bit_timer.sv]
`timescale 1ns/100ps
module csp_bit_timer (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic restart,
  output logic tick
);
  logic [csp_pkg::BIT_CNT_W-1:0] cnt_q;
  localparam logic [csp_pkg::BIT_CNT_W-1:0] LAST =
    csp_pkg::BIT_CNT_W'(csp_pkg::BIT_CYCLES - 1);

  assign tick = (cnt_q == LAST);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (restart || tick) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule

// [hdl/csp_serial_port.sv]
// Functional notes
// - Start or continue sending only while peer_ready_in is high; a character already started still runs to its stop bit after it falls.
// - Peer_ready_in falling mid-transfer raises alarm 086 and reports it.
// - host_ready_out follows operational one enabled cycle later and holds while ce is low.
// - line_quality_in is ignored entirely.
// - Each character framed by a start bit and a stop bit.
// - EIA and ISO sets supported, plus DC1 to DC4 codes.
// - tx_request_out high from data output start until output ends.
// - Permit low: halt within two characters, resume when it returns.
// - DC3 received: stop within ten characters; DC1 resumes.
`timescale 1ns/100ps
module csp_serial_port (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic operational,
  input wire logic char_set,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [1:0] ctl_code_sel,
  input wire logic ctl_code_req,
  input wire logic rx_dc1,
  input wire logic rx_dc3,
  input wire logic peer_ready_in,
  input wire logic tx_permit_in,
  input wire logic line_quality_in,
  input wire logic alarm_clear,
  output logic tx_line,
  output logic host_ready_out,
  output logic tx_request_out,
  output logic alarm_out,
  output logic [7:0] alarm_code,
  output logic char_set_out
);
  csp_pkg::csp_state_t state_q;
  logic [7:0] shift_q;
  logic [2:0] bit_idx_q;
  logic tick;
  logic restart;
  logic alarm_q;
  logic reader_stop_q;
  logic [3:0] stop_cnt_q;
  logic permit_off_q;
  logic [1:0] permit_cnt_q;
  logic may_start;
  logic take;
  logic [7:0] next_char;
  logic frame_end;
  logic unused_lq;

  // Input is deliberately unused
  assign unused_lq = line_quality_in;

  csp_bit_timer u_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .ce(ce),
    .restart(restart),
    .tick(tick)
  );

  // Counted limits let a DC3 or permit drop stop within the allowance
  assign may_start = operational && peer_ready_in && !alarm_q
    && !(reader_stop_q && stop_cnt_q == '0)
    && !(permit_off_q && permit_cnt_q == '0);
  assign take = (state_q == csp_pkg::CSP_IDLE) && may_start
    && (tx_valid || ctl_code_req);
  assign restart = take;
  assign frame_end = (state_q == csp_pkg::CSP_STOP) && tick;

  // Control codes win over data so flow control is not starved
  always_comb begin
    case (ctl_code_sel)
      2'h0: next_char = csp_pkg::CODE_DC1;
      2'h1: next_char = csp_pkg::CODE_DC2;
      2'h2: next_char = csp_pkg::CODE_DC3;
      default: next_char = csp_pkg::CODE_DC4;
    endcase
    if (!ctl_code_req) begin
      next_char = tx_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_ready <= 1'b0;
    end else if (ce) begin
      tx_ready <= (state_q == csp_pkg::CSP_IDLE) && may_start
        && !tx_ready && !ctl_code_req;
    end
  end

  // Framing machine
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= csp_pkg::CSP_IDLE;
      shift_q <= '0;
      bit_idx_q <= '0;
      tx_line <= 1'b1;
    end else if (ce) begin
      case (state_q)
        csp_pkg::CSP_IDLE: begin
          tx_line <= 1'b1;
          if (take) begin
            shift_q <= next_char;
            tx_line <= 1'b0;
            state_q <= csp_pkg::CSP_START;
          end
        end
        csp_pkg::CSP_START: begin
          if (tick) begin
            tx_line <= shift_q[0];
            shift_q <= {1'b0, shift_q[7:1]};
            bit_idx_q <= '0;
            state_q <= csp_pkg::CSP_DATA;
          end
        end
        csp_pkg::CSP_DATA: begin
          if (tick) begin
            if (bit_idx_q == 3'(csp_pkg::DATA_BITS - 1)) begin
              tx_line <= 1'b1;
              state_q <= csp_pkg::CSP_STOP;
            end else begin
              tx_line <= shift_q[0];
              shift_q <= {1'b0, shift_q[7:1]};
              bit_idx_q <= bit_idx_q + 1'b1;
            end
          end
        end
        csp_pkg::CSP_STOP: begin
          if (tick) begin
            state_q <= csp_pkg::CSP_IDLE;
          end
        end
        default: state_q <= csp_pkg::CSP_IDLE;
      endcase
    end
  end

  // Alarm: set wins over clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      alarm_q <= 1'b0;
    end else if (ce) begin
      if (state_q != csp_pkg::CSP_IDLE && !peer_ready_in) begin
        alarm_q <= 1'b1;
      end else if (alarm_clear) begin
        alarm_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      alarm_out <= 1'b0;
      alarm_code <= '0;
    end else if (ce) begin
      alarm_out <= alarm_q;
      alarm_code <= alarm_q ? csp_pkg::ALARM_PEER_DROP : 8'h00;
    end
  end

  // Reader stop allowance
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reader_stop_q <= 1'b0;
      stop_cnt_q <= '0;
    end else if (ce) begin
      if (rx_dc1) begin
        reader_stop_q <= 1'b0;
      end else if (rx_dc3 && !reader_stop_q) begin
        reader_stop_q <= 1'b1;
        // In-flight character consumes one of the ten
        stop_cnt_q <= (state_q != csp_pkg::CSP_IDLE || take) ?
          csp_pkg::STOP_READER_MAX - 4'h1 : csp_pkg::STOP_READER_MAX;
      end else if (reader_stop_q && take && stop_cnt_q != '0) begin
        stop_cnt_q <= stop_cnt_q - 4'h1;
      end
    end
  end

  // Permit allowance counts the character in progress
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      permit_off_q <= 1'b0;
      permit_cnt_q <= '0;
    end else if (ce) begin
      if (tx_permit_in) begin
        permit_off_q <= 1'b0;
      end else if (!permit_off_q) begin
        permit_off_q <= 1'b1;
        permit_cnt_q <= (state_q != csp_pkg::CSP_IDLE || take) ?
          csp_pkg::PERMIT_MAX - 2'h1 : csp_pkg::PERMIT_MAX;
      end else if (take && permit_cnt_q != '0) begin
        permit_cnt_q <= permit_cnt_q - 2'h1;
      end
    end
  end

  // Handshake outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      host_ready_out <= 1'b0;
      tx_request_out <= 1'b0;
      char_set_out <= csp_pkg::SET_EIA;
    end else if (ce) begin
      host_ready_out <= operational;
      char_set_out <= char_set;
      if (take) begin
        tx_request_out <= 1'b1;
      end else if (frame_end
          && !((tx_valid || ctl_code_req) && may_start)) begin
        tx_request_out <= 1'b0;
      end
    end
  end

  a_alarm_on_drop: assert property (@(posedge sys_clk) disable iff (reset)
    ce && state_q != csp_pkg::CSP_IDLE && !peer_ready_in
    |=> alarm_q)
    else $error("peer drop did not raise alarm");
  a_alarm_holds: assert property (@(posedge sys_clk) disable iff (reset)
    alarm_q && !alarm_clear |=> alarm_q)
    else $error("alarm dropped without clear");
  a_no_start_alarm: assert property (@(posedge sys_clk) disable iff (reset)
    take |-> !alarm_q && peer_ready_in)
    else $error("start while alarm or peer not ready");
  a_ready_follows: assert property (@(posedge sys_clk) disable iff (reset)
    ce |=> host_ready_out == $past(operational))
    else $error("host ready mismatch");
  a_start_bit: assert property (@(posedge sys_clk) disable iff (reset)
    ce && take |=> !tx_line && state_q == csp_pkg::CSP_START)
    else $error("missing start bit");
  a_stop_bit: assert property (@(posedge sys_clk) disable iff (reset)
    state_q == csp_pkg::CSP_STOP |-> tx_line)
    else $error("stop bit not high");
  a_request_on: assert property (@(posedge sys_clk) disable iff (reset)
    ce && take |=> tx_request_out)
    else $error("request not raised at start");
  a_permit_cap: assert property (@(posedge sys_clk) disable iff (reset)
    take |-> !(permit_off_q && permit_cnt_q == 2'h0))
    else $error("sent past permit allowance");
  a_reader_cap: assert property (@(posedge sys_clk) disable iff (reset)
    take |-> !(reader_stop_q && stop_cnt_q == 4'h0))
    else $error("sent past stop-reader allowance");
endmodule

// [sim/csp_peer_model.sv]
`timescale 1ns/100ps
module csp_peer_model (
  input wire logic sys_clk,
  input wire logic tx_line,
  input wire logic host_ready_out,
  input wire logic powered,
  output logic peer_ready_in,
  output logic [7:0] rx_byte,
  output logic frame_err,
  output int rx_cnt
);
  localparam int BT = csp_pkg::BIT_CYCLES;
  // Ready follows power-up state only
  assign peer_ready_in = powered;
  initial begin
    rx_byte = 8'h00;
    frame_err = 1'b0;
    rx_cnt = 0;
    forever begin
      @(posedge sys_clk);
      // Ignore the line while the host is not ready
      if (tx_line === 1'b0 && host_ready_out === 1'b1) begin
        repeat (BT / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BT) @(posedge sys_clk);
          rx_byte[i] = tx_line;
        end
        repeat (BT) @(posedge sys_clk);
        frame_err = (tx_line !== 1'b1);
        rx_cnt++;
      end
    end
  end
endmodule

// [sim/cnc_serial_handshake_port_tb.sv]
`timescale 1ns/100ps
module cnc_serial_handshake_port_tb;
  localparam int FR = 10 * csp_pkg::BIT_CYCLES;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic operational = 1'b0;
  logic char_set = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [1:0] ctl_code_sel = 2'h0;
  logic ctl_code_req = 1'b0;
  logic rx_dc1 = 1'b0;
  logic rx_dc3 = 1'b0;
  logic tx_permit_in = 1'b1;
  logic line_quality_in = 1'b0;
  logic alarm_clear = 1'b0;
  logic powered = 1'b1;
  logic peer_ready_in, tx_ready, tx_line, host_ready_out, tx_request_out;
  logic alarm_out, char_set_out, frame_err;
  logic [7:0] alarm_code, rx_byte;
  int rx_cnt, n;
  int err_count = 0;
  int comparisons = 0;
  int seed = 39833;
  always #2.5 sys_clk = ~sys_clk;
  // Random noise on an input that must have no effect
  always @(posedge sys_clk) line_quality_in <= 1'($random(seed));
  csp_serial_port dut (.sys_clk(sys_clk), .reset(reset), .ce(ce),
    .operational(operational), .char_set(char_set), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .ctl_code_sel(ctl_code_sel),
    .ctl_code_req(ctl_code_req), .rx_dc1(rx_dc1), .rx_dc3(rx_dc3),
    .peer_ready_in(peer_ready_in), .tx_permit_in(tx_permit_in),
    .line_quality_in(line_quality_in), .alarm_clear(alarm_clear),
    .tx_line(tx_line), .host_ready_out(host_ready_out),
    .tx_request_out(tx_request_out), .alarm_out(alarm_out),
    .alarm_code(alarm_code), .char_set_out(char_set_out));
  csp_peer_model peer (.sys_clk(sys_clk), .tx_line(tx_line),
    .host_ready_out(host_ready_out), .powered(powered),
    .peer_ready_in(peer_ready_in), .rx_byte(rx_byte),
    .frame_err(frame_err), .rx_cnt(rx_cnt));
  // Channel bit k lands on index k-1
  function automatic logic [7:0] dc_code(input logic [1:0] s);
    case (s)
      2'h0: dc_code = 8'h10 | 8'h01;
      2'h1: dc_code = 8'h10 | 8'h02;
      2'h2: dc_code = 8'h80 | 8'h10 | 8'h02 | 8'h01;
      default: dc_code = 8'h10 | 8'h04;
    endcase
  endfunction
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic send(input logic code, input logic [7:0] d,
                      input logic [1:0] s);
    int c0;
    c0 = rx_cnt;
    @(posedge sys_clk);
    tx_data <= d;
    ctl_code_sel <= s;
    ctl_code_req <= code;
    tx_valid <= !code;
    n = 0;
    while (tx_line !== 1'b0 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    check("rts on", {7'h00, tx_request_out}, 8'h01);
    @(posedge sys_clk);
    tx_valid <= 1'b0;
    ctl_code_req <= 1'b0;
    @(negedge sys_clk);
    check("busy", {7'h00, tx_ready}, 8'h00);
    n = 0;
    while (rx_cnt == c0 && n < 2 * FR) begin
      @(negedge sys_clk);
      n++;
    end
    check("rx byte", rx_byte, code ? dc_code(s) : d);
    check("stop bit", {7'h00, frame_err}, 8'h00);
    repeat (csp_pkg::BIT_CYCLES) @(negedge sys_clk);
    check("rts off", {7'h00, tx_request_out}, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    check("idle line", {7'h00, tx_line}, 8'h01);
    check("er low", {7'h00, host_ready_out}, 8'h00);
    @(posedge sys_clk);
    operational <= 1'b1;
    char_set <= csp_pkg::SET_ISO;
    repeat (3) @(negedge sys_clk);
    check("er high", {7'h00, host_ready_out}, 8'h01);
    check("set", {7'h00, char_set_out}, 8'h01);
    @(posedge sys_clk);
    ce <= 1'b0;
    operational <= 1'b0;
    repeat (3) @(negedge sys_clk);
    check("ce hold", {7'h00, host_ready_out}, 8'h01);
    @(posedge sys_clk);
    ce <= 1'b1;
    operational <= 1'b1;
    repeat (2) @(negedge sys_clk);
    for (int i = 0; i < 4; i++)
      send(1'b1, 8'h00, 2'(i));
    send(1'b0, 8'h00, 2'h0);
    send(1'b0, 8'hFF, 2'h0);
    repeat (3) send(1'b0, 8'($random(seed)), 2'h0);
    @(posedge sys_clk);
    tx_data <= 8'hA5;
    tx_valid <= 1'b1;
    repeat (FR / 2) @(posedge sys_clk);
    powered <= 1'b0;
    repeat (3) @(negedge sys_clk);
    check("alarm", {7'h00, alarm_out}, 8'h01);
    check("alarm code", alarm_code, 8'h56);
    @(posedge sys_clk);
    powered <= 1'b1;
    repeat (2 * FR) @(negedge sys_clk);
    n = rx_cnt;
    repeat (2 * FR) @(negedge sys_clk);
    check("held", 8'(rx_cnt - n), 8'h00);
    check("latched", {7'h00, alarm_out}, 8'h01);
    @(posedge sys_clk);
    alarm_clear <= 1'b1;
    @(posedge sys_clk);
    alarm_clear <= 1'b0;
    repeat (3) @(negedge sys_clk);
    check("cleared", {7'h00, alarm_out}, 8'h00);
    check("code clr", alarm_code, 8'h00);
    repeat (FR / 3) @(posedge sys_clk);
    tx_permit_in <= 1'b0;
    n = rx_cnt;
    repeat (6 * FR) @(negedge sys_clk);
    check("permit", {7'h00, rx_cnt - n <= 2}, 8'h01);
    @(posedge sys_clk);
    tx_permit_in <= 1'b1;
    n = rx_cnt;
    repeat (2 * FR) @(negedge sys_clk);
    check("resume", {7'h00, rx_cnt > n}, 8'h01);
    @(posedge sys_clk);
    rx_dc3 <= 1'b1;
    n = rx_cnt;
    @(posedge sys_clk);
    rx_dc3 <= 1'b0;
    repeat (13 * FR) @(negedge sys_clk);
    check("dc3", {7'h00, rx_cnt - n <= 10}, 8'h01);
    @(posedge sys_clk);
    rx_dc1 <= 1'b1;
    n = rx_cnt;
    @(posedge sys_clk);
    rx_dc1 <= 1'b0;
    repeat (2 * FR) @(negedge sys_clk);
    check("dc1", {7'h00, rx_cnt > n}, 8'h01);
    @(posedge sys_clk);
    tx_valid <= 1'b0;
    operational <= 1'b0;
    repeat (3) @(negedge sys_clk);
    check("er off", {7'h00, host_ready_out}, 8'h00);
    finish_test();
  end
  // Whole run needs about 12k cycles
  initial begin
    #150000;
    err_count++;
    finish_test();
  end
endmodule
